// [design/sei_slave.sv]
// Two-wire serial memory slave with page buffer and internal write cycle
`timescale 1ns/1ps
`include "sei_defines.svh"
module sei_slave
    import sei_pkg::*;
#(
    parameter int WRITE_CYCLES = `SEI_WRITE_CYCLES,
    // Arbitrary device type identifier
    parameter logic [3:0] DEV_TYPE_ID = 4'h5
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic chip_sel_pin_2,
    input wire logic chip_sel_pin_1,
    input wire logic chip_sel_pin_0,
    input wire logic write_inhibit,
    output logic write_busy
);

    sei_state_t st_q;
    logic link_bit_q;
    sei_pins_t raw_pins;
    sei_pins_t sync_pins;
    sei_pins_t prev_q;
    logic sample_q;
    logic [3:0] bitcnt_q;
    logic ack_ph_q;
    logic [`SEI_BYTE_W-1:0] shreg_q;
    logic [`SEI_BYTE_W-1:0] tx_q;
    logic mack_q;
    logic last_ack_q;
    logic oe_n_q;
    logic [`SEI_OFS_HI:0] ahi_q;
    logic [`SEI_ADDR_W-1:0] addr_q;
    logic [`SEI_ADDR_W-1:0] page_ptr_q;
    logic [`SEI_PAGE_DEPTH-1:0] pend_q;
    logic [`SEI_WCNT_W-1:0] wcnt_q;
    logic [`SEI_BYTE_W-1:0] pbuf [`SEI_PAGE_DEPTH];
    logic [`SEI_BYTE_W-1:0] mem [`SEI_MEM_DEPTH];

    logic rise_ev;
    logic fall_ev;
    logic start_ev;
    logic stop_ev;
    logic bit_in;
    logic busy;
    logic active;
    logic byte_done;
    logic ack_end;
    logic shift_ev;
    logic match;
    logic wr_take;
    logic commit_stop;
    logic wdone;
    logic rd_first;
    logic rd_more;
    logic [`SEI_ADDR_W-1:0] rd_next;
    logic [`SEI_OFS_HI:0] widx;
    logic [2:0] bitsel;

    // Link side: capture data on the bus clock edge itself
    always_ff @(posedge scl) begin
        link_bit_q <= sda_i; // R8
    end

    assign raw_pins = {scl, sda_i, link_bit_q, write_inhibit,
                       chip_sel_pin_2, chip_sel_pin_1, chip_sel_pin_0};

    sei_sync u_sync (
        .clock(clock),
        .reset(reset),
        .d(raw_pins),
        .q(sync_pins)
    );

    always_ff @(posedge clock) begin
        if (reset) begin
            prev_q <= `SEI_PIN_IDLE;
        end else begin
            prev_q <= sync_pins;
        end
    end

    // Captured bit is read one cycle after the seen rise so it has settled
    always_ff @(posedge clock) begin
        if (reset) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= rise_ev;
        end
    end

    assign rise_ev = sync_pins.scl & ~prev_q.scl;
    assign fall_ev = ~sync_pins.scl & prev_q.scl;
    assign start_ev = sync_pins.scl & prev_q.scl & prev_q.sda & ~sync_pins.sda; // R4
    assign stop_ev = sync_pins.scl & prev_q.scl & ~prev_q.sda & sync_pins.sda; // R5
    assign bit_in = sync_pins.samp;

    assign busy = (st_q == ST_BUSY);
    assign active = (st_q != ST_IDLE) && !busy;
    assign byte_done = active & fall_ev & ~ack_ph_q & (bitcnt_q == `SEI_ACK_SLOT);
    assign ack_end = active & fall_ev & ack_ph_q;
    assign shift_ev = active & sample_q & ~ack_ph_q & (bitcnt_q != `SEI_ACK_SLOT);
    assign match = (shreg_q[`SEI_ID_HI:`SEI_ID_LO] == DEV_TYPE_ID) && // R10
                   (shreg_q[`SEI_CE_HI:`SEI_CE_LO] == sync_pins.ce); // R11
    assign wr_take = byte_done & (st_q == ST_WDATA) & ~sync_pins.wp; // R1 R25
    assign commit_stop = stop_ev & (st_q == ST_WDATA) & ~ack_ph_q &
                         (bitcnt_q == `SEI_CNT_ONE) & last_ack_q &
                         (pend_q != `SEI_PEND_NONE); // R16
    assign wdone = busy & (wcnt_q == `SEI_WCNT_W'(WRITE_CYCLES - 1));
    assign rd_first = ack_end & (st_q == ST_DEVSEL) & shreg_q[`SEI_RW_BIT]; // R12
    assign rd_more = ack_end & (st_q == ST_RDATA) & mack_q; // R19
    assign rd_next = addr_q + `SEI_ADDR_ONE; // R21
    assign widx = wcnt_q[`SEI_OFS_HI:0];
    assign bitsel = `SEI_BIT_TOP - bitcnt_q[2:0];

    // Protocol state
    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= ST_IDLE; // R3
        end else if (busy) begin
            if (wdone) begin
                st_q <= ST_IDLE; // R18
            end
        end else if (start_ev) begin
            st_q <= ST_DEVSEL; // R4
        end else if (stop_ev) begin
            st_q <= commit_stop ? ST_BUSY : ST_IDLE; // R5 R16
        end else if (byte_done && st_q == ST_DEVSEL && !match) begin
            st_q <= ST_IDLE; // R13
        end else if (ack_end) begin
            case (st_q)
                ST_DEVSEL: st_q <= shreg_q[`SEI_RW_BIT] ? ST_RDATA : ST_ADDRH; // R12 R14
                ST_ADDRH: st_q <= ST_ADDRL; // R14
                ST_ADDRL: st_q <= ST_WDATA; // R14
                ST_RDATA: st_q <= mack_q ? ST_RDATA : ST_IDLE; // R22 R6
                default: st_q <= st_q;
            endcase
        end
    end

    // Bit counter and acknowledge phase
    always_ff @(posedge clock) begin
        if (reset || start_ev) begin
            bitcnt_q <= `SEI_CNT_ZERO;
            ack_ph_q <= 1'b0;
        end else if (shift_ev) begin
            bitcnt_q <= bitcnt_q + `SEI_CNT_ONE; // R8
        end else if (byte_done) begin
            ack_ph_q <= 1'b1; // R7
        end else if (ack_end) begin
            ack_ph_q <= 1'b0;
            bitcnt_q <= `SEI_CNT_ZERO;
        end
    end

    // Incoming bits, most significant first
    always_ff @(posedge clock) begin
        if (reset) begin
            shreg_q <= `SEI_BYTE_ZERO;
        end else if (shift_ev) begin
            shreg_q <= {shreg_q[`SEI_BYTE_W-2:0], bit_in}; // R9
        end
    end

    // Master acknowledge seen in the ninth rising edge of a read byte
    always_ff @(posedge clock) begin
        if (reset) begin
            mack_q <= 1'b0;
        end else if (active && sample_q && ack_ph_q) begin
            mack_q <= ~bit_in; // R22
        end
    end

    // Remembers whether the latest data byte was acknowledged
    always_ff @(posedge clock) begin
        if (reset || start_ev) begin
            last_ack_q <= 1'b0;
        end else if (byte_done && st_q == ST_WDATA) begin
            last_ack_q <= ~sync_pins.wp; // R2
        end
    end

    // Address pointers
    always_ff @(posedge clock) begin
        if (reset) begin
            ahi_q <= `SEI_OFS_W'(0);
            addr_q <= `SEI_ADDR_ZERO;
            page_ptr_q <= `SEI_ADDR_ZERO;
        end else if (wdone) begin
            addr_q <= page_ptr_q; // R17
        end else if (byte_done && st_q == ST_ADDRH) begin
            ahi_q <= shreg_q[`SEI_OFS_HI:0]; // R15 R24
        end else if (byte_done && st_q == ST_ADDRL) begin
            addr_q <= {ahi_q, shreg_q}; // R15 R24
            page_ptr_q <= {ahi_q, shreg_q};
        end else if (wr_take) begin
            page_ptr_q <= {page_ptr_q[`SEI_PAGE_HI:`SEI_PAGE_LO],
                           page_ptr_q[`SEI_OFS_HI:0] + `SEI_OFS_ONE}; // R20
        end else if (ack_end && st_q == ST_RDATA) begin
            addr_q <= rd_next; // R21
        end
    end

    // Page latch; aborted writes drop whatever was latched
    always_ff @(posedge clock) begin
        if (reset || wdone) begin
            pend_q <= `SEI_PEND_NONE;
        end else if (!busy && (start_ev || (stop_ev && !commit_stop))) begin
            pend_q <= `SEI_PEND_NONE; // R16
        end else if (wr_take) begin
            pend_q[page_ptr_q[`SEI_OFS_HI:0]] <= 1'b1; // R25
        end
    end

    always_ff @(posedge clock) begin
        if (wr_take) begin
            pbuf[page_ptr_q[`SEI_OFS_HI:0]] <= shreg_q; // R20 R25
        end
    end

    // Internal write cycle: one latched byte per cycle, then the rest is dead time
    always_ff @(posedge clock) begin
        if (reset || !busy) begin
            wcnt_q <= `SEI_WCNT_ZERO;
        end else begin
            wcnt_q <= wcnt_q + `SEI_WCNT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (busy && wcnt_q < `SEI_COMMIT_CNT && pend_q[widx]) begin
            mem[{page_ptr_q[`SEI_PAGE_HI:`SEI_PAGE_LO], widx}] <= pbuf[widx]; // R1 R25
        end
    end

    // Outgoing read byte
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_q <= `SEI_BYTE_ZERO;
        end else if (rd_first) begin
            tx_q <= mem[addr_q]; // R19
        end else if (rd_more) begin
            tx_q <= mem[rd_next]; // R19 R21
        end
    end

    // Open-drain driver; drives data only from a falling clock so it is stable while high; start and stop release it
    always_ff @(posedge clock) begin
        if (reset || busy || !active || start_ev || stop_ev) begin
            oe_n_q <= 1'b1; // R3 R18
        end else if (byte_done) begin
            case (st_q)
                ST_DEVSEL: oe_n_q <= ~match; // R13
                ST_ADDRH: oe_n_q <= 1'b0; // R14
                ST_ADDRL: oe_n_q <= 1'b0; // R14
                ST_WDATA: oe_n_q <= sync_pins.wp; // R2
                default: oe_n_q <= 1'b1; // R7
            endcase
        end else if (rd_first) begin
            oe_n_q <= mem[addr_q][`SEI_MSB_BIT];
        end else if (rd_more) begin
            oe_n_q <= mem[rd_next][`SEI_MSB_BIT];
        end else if (ack_end) begin
            oe_n_q <= 1'b1; // R7
        end else if (fall_ev && !ack_ph_q && st_q == ST_RDATA) begin
            oe_n_q <= tx_q[bitsel];
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = oe_n_q;
    assign write_busy = busy;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_busy_hold;
        (st_q == ST_BUSY) [*8];
    endsequence

    sequence s_released;
        sda_oe_n [*2];
    endsequence

    property p_inhibit_keep;
        (byte_done && st_q == ST_WDATA && sync_pins.wp) |=> pend_q == $past(pend_q);
    endproperty
    a_inhibit_keep: assert property (p_inhibit_keep) else $error("inhibited byte latched"); // R1

    property p_inhibit_nack;
        (byte_done && st_q == ST_WDATA && sync_pins.wp) |=> sda_oe_n;
    endproperty
    a_inhibit_nack: assert property (p_inhibit_nack) else $error("inhibited byte acked"); // R2

    property p_reset_standby;
        $fell(reset) |-> (st_q == ST_IDLE && sda_oe_n && pend_q == `SEI_PEND_NONE);
    endproperty
    a_reset_standby: assert property (p_reset_standby) else $error("not standby after reset"); // R3

    property p_start_open;
        (start_ev && !busy) |=> (st_q == ST_DEVSEL && bitcnt_q == `SEI_CNT_ZERO);
    endproperty
    a_start_open: assert property (p_start_open) else $error("start not taken"); // R4

    property p_stop_end;
        (stop_ev && !busy && !commit_stop) |=> (st_q == ST_IDLE) ##1 sda_oe_n;
    endproperty
    a_stop_end: assert property (p_stop_end) else $error("stop did not end transfer"); // R5

    property p_read_nack;
        (ack_end && st_q == ST_RDATA && !mack_q) |=> (st_q == ST_IDLE && sda_oe_n);
    endproperty
    a_read_nack: assert property (p_read_nack) else $error("read not ended on nack"); // R22

    property p_select_ack;
        (byte_done && st_q == ST_DEVSEL && match) |=> !sda_oe_n;
    endproperty
    a_select_ack: assert property (p_select_ack) else $error("select not acked"); // R13

    property p_select_miss;
        (byte_done && st_q == ST_DEVSEL && !match) |=> (st_q == ST_IDLE) ##0 s_released;
    endproperty
    a_select_miss: assert property (p_select_miss) else $error("foreign select answered"); // R11

    property p_write_trigger;
        commit_stop |=> s_busy_hold;
    endproperty
    a_write_trigger: assert property (p_write_trigger) else $error("write cycle not held"); // R16

    property p_busy_deaf;
        busy |-> (sda_oe_n && !byte_done && !ack_end);
    endproperty
    a_busy_deaf: assert property (p_busy_deaf) else $error("bus served while writing"); // R18

    property p_addr_after_write;
        wdone |=> (addr_q == $past(page_ptr_q) && st_q == ST_IDLE);
    endproperty
    a_addr_after_write: assert property (p_addr_after_write) else $error("address not advanced"); // R17

endmodule

// [design/sei_defines.svh]
// Constants of the two-wire serial memory slave
// Behaviour
// [R1] Write-inhibit high blocks all array writes; the code samples it only at each data byte, not during the write cycle
// [R2] Inhibited: ack select/address, nack data bytes
// [R3] Ignore bus in reset, then enter standby
// [R4] Start opens transfers; watched except while writing
// [R5] Stop ends the current communication
// [R6] Read nack then stop returns to standby
// [R7] Receiver pulls data low in ninth clock
// [R8] Data sampled on each rising clock edge
// [R9] Master starts, sends select byte MSB first
// [R10] Select byte: type id, chip address, direction
// [R11] Respond only if chip address matches pins
// [R12] Direction bit one reads, zero writes
// [R13] Ack matching select byte, else standby
// [R14] Write: ack select, two address bytes, data
// [R15] High address byte first; extra bits ignored
// [R16] Write cycle only on stop in slot ten
// [R17] After write, address follows last modified byte
// [R18] During write cycle, driver off, bus ignored
// [R19] Sequential read streams one or more bytes
// [R20] Page write wraps within 32-byte page
// [R21] Read address increments, wraps to zero
// [R22] No master ack after read byte: standby
// [R23] Random read: dummy write, restart, read select
// [R24] Low thirteen address bits select the byte
// [R25] Only acknowledged bytes reach the array
`ifndef SEI_DEFINES_SVH
`define SEI_DEFINES_SVH

`define SEI_ADDR_W 13
`define SEI_MEM_DEPTH 8192
`define SEI_BYTE_W 8
`define SEI_PAGE_DEPTH 32
`define SEI_OFS_W 5
`define SEI_OFS_HI 4
`define SEI_PAGE_HI 12
`define SEI_PAGE_LO 5
`define SEI_ID_HI 7
`define SEI_ID_LO 4
`define SEI_CE_HI 3
`define SEI_CE_LO 1
`define SEI_RW_BIT 0
`define SEI_MSB_BIT 7
`define SEI_CNT_ZERO 4'h0
`define SEI_CNT_ONE 4'h1
`define SEI_ACK_SLOT 4'h8
`define SEI_BIT_TOP 3'h7
`define SEI_ADDR_ONE 13'h0001
`define SEI_OFS_ONE 5'h01
`define SEI_PEND_NONE 32'h00000000
`define SEI_ADDR_ZERO 13'h0000
`define SEI_BYTE_ZERO 8'h00
`define SEI_PIN_IDLE 7'h60
`define SEI_WCNT_W 21
`define SEI_WCNT_ZERO 21'h000000
`define SEI_WCNT_ONE 21'h000001
`define SEI_COMMIT_CNT 21'h000020
`define SEI_CLK_PERIOD_NS 4
`define SEI_WRITE_TIME_NS 16000
`define SEI_WRITE_CYCLES (`SEI_WRITE_TIME_NS / `SEI_CLK_PERIOD_NS)

`endif

// [design/sei_pkg.sv]
// Types shared by the serial memory slave
package sei_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEVSEL = 3'h1,
        ST_ADDRH = 3'h3,
        ST_ADDRL = 3'h2,
        ST_WDATA = 3'h6,
        ST_BUSY = 3'h7,
        ST_RDATA = 3'h5
    } sei_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic samp;
        logic wp;
        logic [2:0] ce;
    } sei_pins_t;

endpackage

// [design/sei_sync.sv]
// Two-stage synchroniser for the pin group
`timescale 1ns/1ps
`include "sei_defines.svh"
module sei_sync
    import sei_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire sei_pins_t d,
    output sei_pins_t q
);

    sei_pins_t meta_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= `SEI_PIN_IDLE;
            q <= `SEI_PIN_IDLE;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// [testbench/sei_bus_master.sv]
// Behavioural two-wire bus master that makes the link clock only inside frames
`timescale 1ns/1ps
module sei_bus_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line,
    output logic rsp_stb,
    output logic [7:0] rsp_val
);
    // 125 ns bit period, high and low halves equal
    localparam realtime QTR = 31.25;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rsp_stb = 1'b0;
        rsp_val = 8'h00;
    end

    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        #QTR scl = 1'b1;
        #QTR r = sda_line;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // Also serves as a repeated start when the clock is low
    task automatic start();
        sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #(2 * QTR);
    endtask

    task automatic report(input logic [7:0] v);
        rsp_val = v;
        rsp_stb = 1'b1;
        #1 rsp_stb = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        report({7'h00, r});
    endtask

    task automatic rd_byte(input logic last);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
        bit_x(last, r);
        report(v);
    endtask
endmodule

// [testbench/sei_slave_bench.sv]
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
module sei_slave_bench;
    // Long enough for a busy poll to land inside the write cycle
    localparam int WCYC = 1000;
    // Arbitrary type code, handed to the design as well
    localparam logic [3:0] TYPE_ID = 4'h5;
    typedef struct {
        string name;
        logic [7:0] val;
    } sei_note_t;
    logic clock, reset, scl, sda_drv, sda_line, sda_o, sda_oe_n;
    logic write_inhibit, write_busy, rsp_stb;
    logic [7:0] rsp_val;
    logic [2:0] ce;
    logic [12:0] pg;
    logic [31:0] seed = 32'h00016c7e;
    int err_total = 0;
    int checks_done = 0;
    sei_note_t notes[$];
    logic [7:0] mem [0:8191];
    logic [7:0] wdat [0:3];

    // Open-drain wire with pull-up
    assign sda_line = sda_drv & (sda_oe_n | sda_o);

    sei_slave #(.WRITE_CYCLES(WCYC), .DEV_TYPE_ID(TYPE_ID)) u_sei_slave (
        .clock(clock), .reset(reset), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .chip_sel_pin_2(ce[2]), .chip_sel_pin_1(ce[1]),
        .chip_sel_pin_0(ce[0]), .write_inhibit(write_inhibit), .write_busy(write_busy)
    );
    sei_bus_master u_sei_bus_master (
        .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line), .rsp_stb(rsp_stb),
        .rsp_val(rsp_val)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] sel(input logic [2:0] c, input logic rw);
        return {TYPE_ID, c, rw};
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    initial begin
        sei_note_t n;
        forever begin
            @(posedge rsp_stb);
            if (notes.size() == 0) begin
                err_total++;
                $display("[ERR] result expected none seen %h", rsp_val);
            end else begin
                n = notes.pop_front();
                chk(n.name, n.val, rsp_val);
            end
        end
    end

    task automatic wb(input string n, input logic [7:0] b, input logic [7:0] e);
        notes.push_back('{n, e});
        u_sei_bus_master.wr_byte(b);
    endtask

    task automatic rb(input string n, input logic [7:0] e, input logic last);
        notes.push_back('{n, e});
        u_sei_bus_master.rd_byte(last);
    endtask

    task automatic addr(input logic [12:0] a);
        logic [2:0] up;
        up = 3'(rnd());
        u_sei_bus_master.start();
        wb("select write", sel(ce, 1'b0), 8'h00);
        wb("address high", {up, a[12:8]}, 8'h00);
        wb("address low", a[7:0], 8'h00);
    endtask

    task automatic settle(input logic busy);
        int k;
        k = 0;
        repeat (4) @(posedge clock);
        #1;
        chk("write busy", {7'h00, busy}, {7'h00, write_busy});
        if (busy) begin
            u_sei_bus_master.start();
            wb("busy poll", sel(ce, 1'b0), 8'h01);
            u_sei_bus_master.stop();
        end
        while (write_busy !== 1'b0 && k < 1100) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk("write done", 8'h00, {7'h00, write_busy});
    endtask

    task automatic write(input logic [12:0] a, input int n);
        addr(a);
        for (int i = 0; i < n; i++) begin
            wb("data ack", wdat[i], {7'h00, write_inhibit});
            if (!write_inhibit) mem[{a[12:5], 5'(a[4:0] + i)}] = wdat[i];
        end
        u_sei_bus_master.stop();
        settle(!write_inhibit);
    endtask

    task automatic read(input logic [12:0] a, input int n, input logic rnda);
        if (rnda) addr(a);
        u_sei_bus_master.start();
        wb("select read", sel(ce, 1'b1), 8'h00);
        for (int i = 0; i < n; i++) rb("read data", mem[13'(a + i)], i == n - 1);
        u_sei_bus_master.stop();
    endtask

    task automatic done(input string n);
        $display("test %s finished, errors so far %0d", n, err_total);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        err_total++;
        $display("[ERR] watchdog expected finish seen hang");
        close_out();
    end

    initial begin
        reset = 1'b1;
        write_inhibit = 1'b0;
        ce = 3'(rnd());
        pg = 13'h0400 | (13'(rnd()) & 13'h03e0);
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        repeat (4) @(posedge clock);
        wdat[0] = 8'(rnd());
        write(pg + 13'd1, 1);
        done("byte write");
        for (int i = 0; i < 3; i++) wdat[i] = 8'(rnd());
        write(pg + 13'd30, 3);
        read(pg + 13'd1, 1, 1'b0);
        read(pg, 2, 1'b1);
        done("page write");
        @(posedge clock);
        #1 write_inhibit = 1'b1;
        write(pg, 2);
        @(posedge clock);
        #1 write_inhibit = 1'b0;
        read(pg, 1, 1'b1);
        done("inhibit");
        for (int i = 1; i < 8; i++) begin
            u_sei_bus_master.start();
            wb("foreign chip", sel(ce ^ 3'(i), 1'b1), 8'h01);
            u_sei_bus_master.stop();
        end
        u_sei_bus_master.start();
        wb("foreign type", {TYPE_ID ^ 4'h3, ce, 1'b1}, 8'h01);
        u_sei_bus_master.stop();
        done("select decode");
        addr(pg + 13'd7);
        u_sei_bus_master.stop();
        settle(1'b0);
        done("early stop");
        wdat[0] = 8'(rnd());
        write(13'h1fff, 1);
        wdat[0] = 8'(rnd());
        write(13'h0000, 1);
        read(13'h1fff, 2, 1'b1);
        done("address wrap");
        @(posedge clock);
        #1 reset = 1'b1;
        u_sei_bus_master.start();
        wb("select in reset", sel(ce, 1'b1), 8'h01);
        u_sei_bus_master.stop();
        @(posedge clock);
        #1 reset = 1'b0;
        repeat (4) @(posedge clock);
        read(pg + 13'd1, 1, 1'b1);
        done("reset");
        close_out();
    end
endmodule
